// >>> port_irq_pkg.sv
/*
  Package for the input-port and interrupt block: register byte offsets,
  field positions, reset values and the packed carriers shared by the design.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package port_irq_pkg;

  localparam logic [7:0] OFF_DED_LEVELS   = 8'h00;
  localparam logic [7:0] OFF_DED_ENABLES  = 8'h04;
  localparam logic [7:0] OFF_DED_DATA     = 8'h08;
  localparam logic [7:0] OFF_TRIG_SELECT  = 8'h0c;
  localparam logic [7:0] OFF_PORT_GROUP   = 8'h10;
  localparam logic [7:0] OFF_PORT_LEVELS  = 8'h14;
  localparam logic [7:0] OFF_GIO_IN       = 8'h18;
  localparam logic [7:0] OFF_GIO_OUT      = 8'h1c;
  localparam logic [7:0] OFF_GIO_DIR      = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h28;

  localparam int BIT_DED_TRIG  = 0;
  localparam int BIT_PORT_TRIG = 1;
  localparam int BIT_GROUP_EN  = 0;

  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Status layout: bits 3:0 dedicated inputs, bits 7:4 port pins.
  typedef struct packed {
    logic [3:0] port;
    logic [3:0] ded;
  } irq_vec_t;

  typedef struct packed {
    logic [7:0] group_b;
    logic [7:0] group_a;
  } gio_t;

endpackage

// >>> input_port_interrupt_logic.sv
/*
  Input-port and interrupt logic: four dedicated interrupt inputs, four
  input-only port pins and sixteen general I/O pins behind an AXI4-Lite slave.
  Assumes all pin inputs are asynchronous to aclk and the master keeps at most
  one write and one read outstanding.
*/
`timescale 1ns/1ns

module input_port_interrupt_logic
  import port_irq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  dedicated_irq_inputs,
  input  wire logic [3:0]  input_only_port_pins,
  input  wire gio_t        gio_in,
  output gio_t             gio_out,
  output gio_t             gio_oe,
  output logic [3:0]       ded_request,
  output logic [3:0]       port_request,
  output logic             irq
);

  logic [3:0]  ded_meta_r, ded_sync_r, ded_prev_r;
  logic [3:0]  port_meta_r, port_sync_r, port_prev_r;
  gio_t        gio_meta_r, gio_sync_r;
  logic [3:0]  ded_en_r, ded_data_r;
  logic        ded_trig_r, port_trig_r, group_en_r;
  gio_t        gio_out_r, gio_dir_r;
  irq_vec_t    status_r, mask_r;
  logic [3:0]  ded_req_nxt, port_req_nxt;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_have_r, w_have_r;
  logic        wr_fire;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        status_wr;
  irq_vec_t    req_vec;

  // Decodes a word address; the low two bits are ignored for alignment.
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Two-flop synchronisers for every pin; the dedicated and port pins add a third flop that is read for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_meta_r  <= RST_NIBBLE;
      ded_sync_r  <= RST_NIBBLE;
      ded_prev_r  <= RST_NIBBLE;
      port_meta_r <= RST_NIBBLE;
      port_sync_r <= RST_NIBBLE;
      port_prev_r <= RST_NIBBLE;
      gio_meta_r  <= '0;
      gio_sync_r  <= '0;
    end else begin
      ded_meta_r  <= dedicated_irq_inputs;
      ded_sync_r  <= ded_meta_r;
      ded_prev_r  <= ded_sync_r;
      port_meta_r <= input_only_port_pins;
      port_sync_r <= port_meta_r;
      port_prev_r <= port_sync_r;
      gio_meta_r  <= gio_in;
      gio_sync_r  <= gio_meta_r;
    end
  end

  // Level mode ignores the enables: the synchronised level is the request.
  always_comb begin
    if (ded_trig_r) begin
      ded_req_nxt = ded_sync_r;
    end else begin
      ded_req_nxt = ded_sync_r & ~ded_prev_r & ded_en_r;
    end
    if (port_trig_r) begin
      port_req_nxt = port_sync_r;
    end else begin
      port_req_nxt = port_sync_r & ~port_prev_r & {4{group_en_r}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_request  <= RST_NIBBLE;
      port_request <= RST_NIBBLE;
    end else begin
      ded_request  <= ded_req_nxt;
      port_request <= port_req_nxt;
    end
  end

  // Write channel: address and data are accepted in either order.
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= RST_BYTE;
      w_data_r      <= '0;
      w_strb_r      <= RST_NIBBLE;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_is(aw_addr_r, OFF_DED_LEVELS) || addr_is(aw_addr_r, OFF_DED_DATA) ||
                         addr_is(aw_addr_r, OFF_PORT_LEVELS) || addr_is(aw_addr_r, OFF_GIO_IN) ||
                         aw_addr_r > OFF_IRQ_MASK + 8'h03) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers written by software; only byte lanes 0 and 1 carry data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_en_r    <= RST_NIBBLE;
      ded_trig_r  <= 1'b0;
      port_trig_r <= 1'b0;
      group_en_r  <= 1'b0;
      gio_out_r   <= '0;
      gio_dir_r   <= '0;
      mask_r      <= '0;
    end else if (wr_fire && w_strb_r[0]) begin
      if (addr_is(aw_addr_r, OFF_DED_ENABLES)) ded_en_r <= w_data_r[3:0];
      if (addr_is(aw_addr_r, OFF_TRIG_SELECT)) begin
        ded_trig_r  <= w_data_r[BIT_DED_TRIG];
        port_trig_r <= w_data_r[BIT_PORT_TRIG];
      end
      if (addr_is(aw_addr_r, OFF_PORT_GROUP)) group_en_r <= w_data_r[BIT_GROUP_EN];
      if (addr_is(aw_addr_r, OFF_GIO_OUT)) begin
        gio_out_r.group_a <= w_data_r[7:0];
        if (w_strb_r[1]) gio_out_r.group_b <= w_data_r[15:8];
      end
      if (addr_is(aw_addr_r, OFF_GIO_DIR)) begin
        gio_dir_r.group_a <= w_data_r[7:0];
        if (w_strb_r[1]) gio_dir_r.group_b <= w_data_r[15:8];
      end
      if (addr_is(aw_addr_r, OFF_IRQ_MASK)) mask_r <= w_data_r[7:0];
    end
  end

  // One decode of the write-one-to-clear strobe, shared by the data and status flags.
  assign status_wr = wr_fire && w_strb_r[0] && addr_is(aw_addr_r, OFF_IRQ_STATUS);
  assign req_vec   = {port_request, ded_request};

  // Latched interrupt data of the dedicated inputs; a new request wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_data_r <= RST_NIBBLE;
    end else begin
      ded_data_r <= (ded_data_r & ~(status_wr ? w_data_r[3:0] : RST_NIBBLE)) | ded_request;
    end
  end

  // Sticky status: set by requests, cleared by writing one; set wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (req_vec[i]) begin
          status_r[i] <= 1'b1;
        end else if (status_wr && w_data_r[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq     <= 1'b0;
      gio_out <= '0;
      gio_oe  <= '0;
    end else begin
      irq     <= |(status_r & mask_r);
      gio_out <= gio_out_r;
      gio_oe  <= gio_dir_r;
    end
  end

  // Read decode. The port pins deliberately have no interrupt-data word.
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (addr_is(s_axi_araddr, OFF_DED_LEVELS)) rd_word[3:0] = ded_sync_r;
    else if (addr_is(s_axi_araddr, OFF_DED_ENABLES)) rd_word[3:0] = ded_en_r;
    else if (addr_is(s_axi_araddr, OFF_DED_DATA)) rd_word[3:0] = ded_data_r;
    else if (addr_is(s_axi_araddr, OFF_TRIG_SELECT)) rd_word[1:0] = {port_trig_r, ded_trig_r};
    else if (addr_is(s_axi_araddr, OFF_PORT_GROUP)) rd_word[0] = group_en_r;
    else if (addr_is(s_axi_araddr, OFF_PORT_LEVELS)) rd_word[3:0] = port_sync_r;
    else if (addr_is(s_axi_araddr, OFF_GIO_IN)) rd_word[15:0] = gio_sync_r;
    else if (addr_is(s_axi_araddr, OFF_GIO_OUT)) rd_word[15:0] = gio_out_r;
    else if (addr_is(s_axi_araddr, OFF_GIO_DIR)) rd_word[15:0] = gio_dir_r;
    else if (addr_is(s_axi_araddr, OFF_IRQ_STATUS)) rd_word[7:0] = status_r;
    else if (addr_is(s_axi_araddr, OFF_IRQ_MASK)) rd_word[7:0] = mask_r;
    else rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  sequence ded_rise_s;
    !ded_prev_r[0] && ded_sync_r[0] && !ded_trig_r;
  endsequence

  chk_ded_level_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_trig_r && ded_sync_r[0] && $stable(ded_trig_r) |=> ded_request[0])
    else $error("level request dropped while dedicated input high");
  chk_ded_edge_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_rise_s ##0 ded_en_r[0] |=> ded_request[0] ##1 (!ded_request[0] || ded_trig_r))
    else $error("edge request not one cycle");
  chk_ded_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !ded_trig_r && !ded_en_r[1] |=> !ded_request[1])
    else $error("disabled dedicated input requested");
  chk_ded_level_ignore_en: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_trig_r && !ded_en_r[2] && ded_sync_r[2] |=> ded_request[2])
    else $error("enable gated level request");
  chk_port_group_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !port_trig_r && !group_en_r |=> port_request == 4'h0)
    else $error("port request with group disabled");
  chk_port_level_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    port_trig_r |=> port_request == $past(port_sync_r))
    else $error("port level request mismatch");
  chk_ded_data_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_request[3] |=> ded_data_r[3])
    else $error("interrupt data not latched");
  chk_gio_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 gio_out == $past(gio_out_r))
    else $error("general output not driven from register");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(status_r & mask_r) |=> irq)
    else $error("unmasked status without interrupt");
  chk_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_r & mask_r) == 8'h00 |=> !irq)
    else $error("interrupt without unmasked status");
  chk_gio_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 gio_oe == $past(gio_dir_r))
    else $error("general output enable not driven from register");

  // Bus handshakes: ready pulses last one cycle and answers hold until taken.
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence reg_wr_s;
    wr_fire && w_strb_r[0];
  endsequence

  chk_awready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held two cycles");
  chk_wready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held two cycles");
  chk_arready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held two cycles");
  chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was taken");
  chk_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 !rd_hit |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  chk_ro_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && addr_is(aw_addr_r, OFF_DED_LEVELS) |=> s_axi_bresp == RESP_SLVERR)
    else $error("write to read-only level word accepted");

  // Read paths return the value that stood when the address was taken.
  chk_ded_level_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 addr_is(s_axi_araddr, OFF_DED_LEVELS) |=> s_axi_rdata[3:0] == $past(ded_sync_r))
    else $error("dedicated level read wrong");
  chk_port_level_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 addr_is(s_axi_araddr, OFF_PORT_LEVELS) |=> s_axi_rdata[3:0] == $past(port_sync_r))
    else $error("port level read wrong");
  chk_ded_data_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 addr_is(s_axi_araddr, OFF_DED_DATA) |=> s_axi_rdata[3:0] == $past(ded_data_r))
    else $error("interrupt data read wrong");
  chk_group_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 addr_is(s_axi_araddr, OFF_PORT_GROUP) |=> s_axi_rdata[0] == $past(group_en_r))
    else $error("group enable read wrong");
  chk_mask_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take_s ##0 addr_is(s_axi_araddr, OFF_IRQ_MASK) |=> s_axi_rdata[7:0] == $past(mask_r))
    else $error("mask read wrong");

  // Control writes land one cycle after the write fires.
  chk_enable_write: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr_s ##0 addr_is(aw_addr_r, OFF_DED_ENABLES) |=> ded_en_r == w_data_r[3:0])
    else $error("dedicated enables not written");
  chk_trig_write: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_wr_s ##0 addr_is(aw_addr_r, OFF_TRIG_SELECT) |=>
      ded_trig_r == w_data_r[BIT_DED_TRIG] && port_trig_r == w_data_r[BIT_PORT_TRIG])
    else $error("trigger selects not written");

  // Port pin requests mirror the dedicated ones, gated by the single group bit.
  sequence port_rise_s;
    !port_prev_r[0] && port_sync_r[0] && !port_trig_r && group_en_r;
  endsequence

  chk_port_edge_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    port_rise_s |=> port_request[0] ##1 (!port_request[0] || port_trig_r))
    else $error("port edge request not one cycle");
  chk_port_level_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
    port_trig_r && !group_en_r && port_sync_r[1] |=> port_request[1])
    else $error("group enable gated level request");
  chk_ded_edge_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !ded_trig_r && ded_prev_r == ded_sync_r |=> ded_request == 4'h0)
    else $error("edge mode request without a rising edge");
  chk_port_edge_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !port_trig_r && port_prev_r == port_sync_r |=> port_request == 4'h0)
    else $error("port edge request without a rising edge");

  // Sticky flags: only a write of one clears them, and a request in the same cycle wins.
  chk_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    status_r[0] && !status_wr |=> status_r[0])
    else $error("status bit lost without a clear");
  chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ded_request[1] && status_wr && w_data_r[1] |=> status_r[1] && ded_data_r[1])
    else $error("clear won over a new request");

endmodule

// >>> pin_source_model.sv
/*
  Behavioural model of the switches outside the interrupt and port pins.
  Assumes the bench asks for new levels just after a rising edge of aclk.
*/
`timescale 1ns/1ns
module pin_source_model
  import port_irq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic [3:0] ded_want,
  input  wire logic [3:0] port_want,
  input  wire gio_t       gio_want,
  output logic [3:0]      ded_pins,
  output logic [3:0]      port_pins,
  output gio_t            gio_pins
);
  // Every level is held a few edges, so no short pulse can reach a level-mode input.
  localparam int MIN_HOLD = 4;
  int held = 0;
  initial begin
    ded_pins = 4'h0;
    port_pins = 4'h0;
    gio_pins = 16'h0000;
  end
  always @(posedge aclk) begin
    held <= held + 1;
    if (held >= MIN_HOLD && {ded_want, port_want, gio_want} != {ded_pins, port_pins, gio_pins}) begin
      ded_pins <= ded_want;
      port_pins <= port_want;
      gio_pins <= gio_want;
      held <= 0;
    end
  end
endmodule

// >>> test_input_port_interrupt_logic.sv
/*
  Self-checking bench for the input-port and interrupt block, with AXI4-Lite
  master tasks and expected values kept in integers.
  Assumes one 250 MHz clock and the byte offsets of port_irq_pkg.
*/
`timescale 1ns/1ns
module test_input_port_interrupt_logic
  import port_irq_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  ded_want, port_want, ded_pins, port_pins, ded_request, port_request;
  gio_t        gio_want, gio_pins, gio_out, gio_oe;
  logic [31:0] w [6];
  logic [7:0]  rw_off [6] = '{OFF_DED_ENABLES, OFF_TRIG_SELECT, OFF_PORT_GROUP, OFF_GIO_OUT, OFF_GIO_DIR, OFF_IRQ_MASK};
  logic [31:0] rw_msk [6] = '{32'hf, 32'h3, 32'h1, 32'hffff, 32'hffff, 32'hff};
  int          n_fail = 0, num_checks = 0, seed = 34, en, mask, st, d, p;

  input_port_interrupt_logic u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dedicated_irq_inputs(ded_pins), .input_only_port_pins(port_pins), .gio_in(gio_pins),
    .gio_out(gio_out), .gio_oe(gio_oe), .ded_request(ded_request), .port_request(port_request), .irq(irq));

  pin_source_model u_pins (
    .aclk(aclk), .ded_want(ded_want), .port_want(port_want), .gio_want(gio_want),
    .ded_pins(ded_pins), .port_pins(port_pins), .gio_pins(gio_pins));

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Reads one register and compares both data and response.
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check(what, rdata, exp);
    check({what, " resp"}, {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic pins(input logic [3:0] dv, input logic [3:0] pv);
    @(posedge aclk);
    ded_want <= dv;
    port_want <= pv;
    repeat (12) @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {ded_want, port_want, gio_want} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd("reset value", rw_off[i], 32'h0, RESP_OKAY);
    rd("unmapped read", 8'h2c, 32'h0, RESP_SLVERR);
    wr(OFF_DED_LEVELS, 32'hf, resp);
    check("read-only write", {30'h0, resp}, {30'h0, RESP_SLVERR});
    repeat (4) begin
      d = $random(seed) & 15;
      p = $random(seed) & 15;
      gio_want <= 16'($random(seed));
      pins(d[3:0], p[3:0]);
      rd("input levels", OFF_DED_LEVELS, d, RESP_OKAY);
      rd("port levels", OFF_PORT_LEVELS, p, RESP_OKAY);
      rd("gio levels", OFF_GIO_IN, {16'h0, gio_want}, RESP_OKAY);
    end
    for (int i = 0; i < 6; i++) begin
      w[i] = $random(seed);
      wr(rw_off[i], w[i], resp);
      rd("read back", rw_off[i], w[i] & rw_msk[i], RESP_OKAY);
    end
    check("gio out", {16'h0, gio_out}, {16'h0, w[3][15:0]});
    check("gio oe", {16'h0, gio_oe}, {16'h0, w[4][15:0]});
    for (int g = 0; g < 2; g++) begin
      en = $random(seed) & 15;
      mask = $random(seed) & 255;
      wr(OFF_TRIG_SELECT, 32'h0, resp);
      wr(OFF_DED_ENABLES, en, resp);
      wr(OFF_PORT_GROUP, g, resp);
      wr(OFF_IRQ_MASK, mask, resp);
      pins(4'h0, 4'h0);
      wr(OFF_IRQ_STATUS, 32'hff, resp);
      pins(4'hf, 4'hf);
      st = (g ? 240 : 0) | en;
      rd("status", OFF_IRQ_STATUS, st, RESP_OKAY);
      rd("irq data", OFF_DED_DATA, en, RESP_OKAY);
      check("edge pulse", {24'h0, port_request, ded_request}, 32'h0);
      check("irq", {31'h0, irq}, {31'h0, (st & mask) != 0});
      wr(OFF_IRQ_MASK, 32'h0, resp);
      rd("status kept", OFF_IRQ_STATUS, st, RESP_OKAY);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(OFF_IRQ_STATUS, st, resp);
      rd("status cleared", OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
    end
    wr(OFF_TRIG_SELECT, 32'h3, resp);
    wr(OFF_DED_ENABLES, 32'h0, resp);
    wr(OFF_PORT_GROUP, 32'h0, resp);
    pins(4'h5, 4'ha);
    repeat (4) begin
      @(posedge aclk);
      check("level request", {24'h0, port_request, ded_request}, 32'ha5);
    end
    pins(4'h0, 4'h0);
    check("level release", {24'h0, port_request, ded_request}, 32'h0);
    wrap_up();
  end
endmodule
